// *** iamd_map.svh ***
// constants for the io / converter / misc instruction decoder
// assumes: included by the decoder only, nothing else
// Functional notes
// - 4-bit port read to A, write from A
// - 2-bit ports use accumulator bits 1 and 0
// - 2-bit port read clears accumulator bits 3,2
// - bitport set-all; indexed clear/set for Y 0..5
// - bitport test skips when indexed bit zero
// - single output set, clear, skip when one
// - single io uses accumulator bit 0 only
// - wake regs read/write, pullup regs write only
// - conversion mode: B,A get result 9:6, 5:2
// - comparator mode: B,A get compare reg nibbles 7:4, 3:0
// - low read: A = result 1:0 then zeros
// - compare load: nop, or B,A into register
// - converter control reg transfers four bits
// - start clears done flag, starts selected operation
// - done test skips and clears unless irq enabled
// - all-zero opcode only advances program counter
// - backup entries act only right after arm
// - power flag test skips, flag unchanged
// - watchdog restart skip/clear; stops after arm
// - clock selects pick circuit, stop on-chip oscillator
// - clock control register transfers with accumulator
// - 10-bit word: 6-bit column, 4-bit row
`ifndef IAMD_MAP_SVH
`define IAMD_MAP_SVH

// ----------------------------------------------------------------
// opcodes (column in 9:4, row in 3:0)
// ----------------------------------------------------------------
`define IAMD_OP_NOP   10'h000
`define IAMD_OP_BKEEP 10'h002
`define IAMD_OP_TSTPW 10'h003
`define IAMD_OP_BSTOP 10'h008
`define IAMD_OP_SETD  10'h011
`define IAMD_OP_CLRDY 10'h014
`define IAMD_OP_SETDY 10'h015
`define IAMD_OP_TSTD  10'h024
`define IAMD_OP_TSTD2 10'h02b
`define IAMD_OP_ARMBK 10'h05b
`define IAMD_OP_WRQ1  10'h204
`define IAMD_OP_WRK1  10'h214
`define IAMD_OP_WRK2  10'h215
`define IAMD_OP_WRMR  10'h216
`define IAMD_OP_WRK0  10'h21b
`define IAMD_OP_WRK   10'h21f
`define IAMD_OP_WRP0  10'h220
`define IAMD_OP_WRP2  10'h222
`define IAMD_OP_WRPU0 10'h22d
`define IAMD_OP_WRPU1 10'h22e
`define IAMD_OP_WRPU2 10'h22f
`define IAMD_OP_LDCMP 10'h239
`define IAMD_OP_RDQ1  10'h244
`define IAMD_OP_RDLO  10'h249
`define IAMD_OP_RDMR  10'h252
`define IAMD_OP_RDK0  10'h256
`define IAMD_OP_RDK1  10'h259
`define IAMD_OP_RDK2  10'h25a
`define IAMD_OP_RDP0  10'h260
`define IAMD_OP_RDP2  10'h262
`define IAMD_OP_RDK   10'h26f
`define IAMD_OP_RDHI  10'h279
`define IAMD_OP_TSTAD 10'h287
`define IAMD_OP_TSTC  10'h289
`define IAMD_OP_CLRC  10'h28c
`define IAMD_OP_SETC  10'h28d
`define IAMD_OP_CERAM 10'h29a
`define IAMD_OP_RCOSC 10'h29b
`define IAMD_OP_ARMWD 10'h29c
`define IAMD_OP_START 10'h29f
`define IAMD_OP_WDRST 10'h2a0

// ----------------------------------------------------------------
// fields, reset values, register map
// ----------------------------------------------------------------
`define IAMD_CMP_MODE  3
`define IAMD_D_LAST    3'h5
`define IAMD_D_ALL     6'h3f
`define IAMD_RST_NIB   4'h0
`define IAMD_RST_LATCH 4'hf
`define IAMD_ADR_CFG   4'h0
`define IAMD_ADR_STAT  4'h4
`define IAMD_ADR_PORT  4'h8

`endif

// *** iamd_pkg.sv ***
// types shared by the instruction decoder and its users
// assumes: iamd_map.svh on the include path
package iamd_pkg;

  // decoder sequencing, one-hot
  typedef enum logic [1:0] {
    IAMD_ST_RUN  = 2'b01,
    IAMD_ST_WORD2 = 2'b10
  } iamd_state_t;

  // register writeback toward the core
  typedef struct packed {
    logic       acc_we;
    logic [3:0] acc;
    logic       b_we;
    logic [3:0] b;
    logic       skip;
    logic       pc_inc;
  } iamd_exec_t;

  // converter request toward the analog block
  typedef struct packed {
    logic       start;
    logic       cmp_mode;
    logic [7:0] cmp_value;
  } iamd_adc_req_t;

endpackage : iamd_pkg

// *** iamd_decoder.sv ***
// io, converter and system-control instruction decoder
// assumes: one word per instr_valid from fetch, A/B/Y from the core,
// skip and pc_inc acted on by fetch, registers on classic wishbone
//
// Chosen here: the placing of the registers and the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none
`include "iamd_map.svh"

module iamd_decoder
(
  input  wire logic               clock,
  input  wire logic               rst_n,
  input  wire logic               instr_valid,
  input  wire logic [9:0]         instr_word,
  input  wire logic [3:0]         acc_in,
  input  wire logic [3:0]         b_in,
  input  wire logic [3:0]         y_in,
  output iamd_pkg::iamd_exec_t    exec,
  input  wire logic [3:0]         p0_pins,
  input  wire logic [3:0]         p1_pins,
  input  wire logic [1:0]         p2_pins,
  input  wire logic [1:0]         p3_pins,
  input  wire logic [5:0]         d_pins,
  input  wire logic               k_pin,
  output logic [3:0]              p0_latch,
  output logic [3:0]              p1_latch,
  output logic [1:0]              p2_latch,
  output logic [1:0]              p3_latch,
  output logic [5:0]              d_latch,
  output logic                    c_latch,
  output logic                    k_latch,
  output logic [11:0]             wake_ctl,
  output logic [11:0]             pullup_ctl,
  input  wire logic [9:0]         conv_result,
  input  wire logic               conv_done,
  output iamd_pkg::iamd_adc_req_t adc_req,
  input  wire logic               power_flag,
  input  wire logic               watchdog_flag_set,
  output logic                    watchdog_stopped,
  output logic                    backup_keep_detector,
  output logic                    backup_full_stop,
  output logic                    select_ceramic_clock,
  output logic                    select_rc_clock,
  output logic                    onchip_osc_stop,
  output logic [3:0]              clock_control_reg,
  input  wire logic               wb_cyc,
  input  wire logic               wb_stb,
  input  wire logic               wb_we,
  input  wire logic [3:0]         wb_adr,
  input  wire logic [3:0]         wb_sel,
  input  wire logic [31:0]        wb_dat_w,
  output logic [31:0]             wb_dat_r,
  output logic                    wb_ack
);

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  iamd_pkg::iamd_state_t state;
  logic [3:0] converter_control_reg;
  logic [7:0] cmp_reg;
  logic       conversion_done_flag;
  logic       watchdog_flag_one;
  logic       conv_irq_enable_bit;
  logic       backup_armed;
  logic       wdt_armed;
  logic       go;
  logic       cmode;
  logic       y_ok;

  // one match per opcode; column and row kept together as 10 bits
  function automatic logic is_op(input logic [9:0] w,
                                 input logic [9:0] op);
    is_op = (w == op);
  endfunction : is_op

  function automatic logic op(input logic [9:0] o);
    op = go && is_op(instr_word, o);
  endfunction : op

  assign go    = instr_valid && (state == iamd_pkg::IAMD_ST_RUN);
  assign cmode = converter_control_reg[`IAMD_CMP_MODE];
  assign y_ok  = (y_in[2:0] <= `IAMD_D_LAST) && !y_in[3];

  // second word of the bitport test carries no action of its own
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      state <= iamd_pkg::IAMD_ST_RUN;
    else if (instr_valid)
    begin
      case (state)
        iamd_pkg::IAMD_ST_RUN:
          if (is_op(instr_word, `IAMD_OP_TSTD))
            state <= iamd_pkg::IAMD_ST_WORD2;
        iamd_pkg::IAMD_ST_WORD2:
          state <= iamd_pkg::IAMD_ST_RUN;
        default:
          state <= iamd_pkg::IAMD_ST_RUN;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // writeback toward the core, one cycle after the word
  // ----------------------------------------------------------------
  // unmatched words fall through with only pc_inc set
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      exec <= '0;
    else
    begin
      exec        <= '0;
      exec.pc_inc <= instr_valid;
      if (op(`IAMD_OP_RDP0) || op(`IAMD_OP_RDP0 + 10'h001))
      begin
        exec.acc_we <= 1'b1;
        exec.acc    <= instr_word[0] ? p1_pins : p0_pins;
      end
      else if (op(`IAMD_OP_RDP2) || op(`IAMD_OP_RDP2 + 10'h001))
      begin
        exec.acc_we <= 1'b1;
        exec.acc    <= {2'h0, instr_word[0] ? p3_pins : p2_pins};
      end
      else if (op(`IAMD_OP_RDK))
      begin
        exec.acc_we <= 1'b1;
        exec.acc    <= {3'h0, k_pin};
      end
      else if (op(`IAMD_OP_RDK0))
      begin
        exec.acc_we <= 1'b1;
        exec.acc    <= wake_ctl[3:0];
      end
      else if (op(`IAMD_OP_RDK1))
      begin
        exec.acc_we <= 1'b1;
        exec.acc    <= wake_ctl[7:4];
      end
      else if (op(`IAMD_OP_RDK2))
      begin
        exec.acc_we <= 1'b1;
        exec.acc    <= wake_ctl[11:8];
      end
      else if (op(`IAMD_OP_RDHI))
      begin
        exec.acc_we <= 1'b1;
        exec.b_we   <= 1'b1;
        exec.b      <= cmode ? cmp_reg[7:4] : conv_result[9:6];
        exec.acc    <= cmode ? cmp_reg[3:0] : conv_result[5:2];
      end
      else if (op(`IAMD_OP_RDLO))
      begin
        exec.acc_we <= 1'b1;
        exec.acc    <= {conv_result[1:0], 2'h0};
      end
      else if (op(`IAMD_OP_RDQ1))
      begin
        exec.acc_we <= 1'b1;
        exec.acc    <= converter_control_reg;
      end
      else if (op(`IAMD_OP_RDMR))
      begin
        exec.acc_we <= 1'b1;
        exec.acc    <= clock_control_reg;
      end
      else if (op(`IAMD_OP_TSTD))
        exec.skip <= y_ok && !d_pins[y_in[2:0]];
      else if (op(`IAMD_OP_TSTC))
        exec.skip <= c_latch;
      else if (op(`IAMD_OP_TSTAD))
        exec.skip <= !conv_irq_enable_bit && conversion_done_flag;
      else if (op(`IAMD_OP_TSTPW))
        exec.skip <= power_flag;
      else if (op(`IAMD_OP_WDRST))
        exec.skip <= watchdog_flag_one;
    end
  end

  // ----------------------------------------------------------------
  // port latches; open-drain ports idle released (all ones)
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      p0_latch <= `IAMD_RST_LATCH;
      p1_latch <= `IAMD_RST_LATCH;
      p2_latch <= 2'(`IAMD_RST_LATCH);
      p3_latch <= 2'(`IAMD_RST_LATCH);
      d_latch  <= `IAMD_D_ALL;
      c_latch  <= 1'b1;
      k_latch  <= 1'b1;
    end
    else
    begin
      if (op(`IAMD_OP_WRP0))
        p0_latch <= acc_in;
      if (op(`IAMD_OP_WRP0 + 10'h001))
        p1_latch <= acc_in;
      if (op(`IAMD_OP_WRP2))
        p2_latch <= acc_in[1:0];
      if (op(`IAMD_OP_WRP2 + 10'h001))
        p3_latch <= acc_in[1:0];
      if (op(`IAMD_OP_SETD))
        d_latch <= `IAMD_D_ALL;
      else if ((op(`IAMD_OP_CLRDY) || op(`IAMD_OP_SETDY)) && y_ok)
        d_latch[y_in[2:0]] <= instr_word[0];
      if (op(`IAMD_OP_SETC))
        c_latch <= 1'b1;
      else if (op(`IAMD_OP_CLRC))
        c_latch <= 1'b0;
      if (op(`IAMD_OP_WRK))
        k_latch <= acc_in[0];
    end
  end

  // ----------------------------------------------------------------
  // wakeup, pull-up and clock control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      wake_ctl          <= '0;
      pullup_ctl        <= '0;
      clock_control_reg <= `IAMD_RST_NIB;
    end
    else
    begin
      if (op(`IAMD_OP_WRK0))
        wake_ctl[3:0] <= acc_in;
      if (op(`IAMD_OP_WRK1))
        wake_ctl[7:4] <= acc_in;
      if (op(`IAMD_OP_WRK2))
        wake_ctl[11:8] <= acc_in;
      if (op(`IAMD_OP_WRPU0))
        pullup_ctl[3:0] <= acc_in;
      if (op(`IAMD_OP_WRPU1))
        pullup_ctl[7:4] <= acc_in;
      if (op(`IAMD_OP_WRPU2))
        pullup_ctl[11:8] <= acc_in;
      if (op(`IAMD_OP_WRMR))
        clock_control_reg <= acc_in;
    end
  end

  // ----------------------------------------------------------------
  // converter control, compare value, done flag
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      converter_control_reg <= `IAMD_RST_NIB;
      cmp_reg               <= '0;
      adc_req               <= '0;
    end
    else
    begin
      adc_req.start    <= op(`IAMD_OP_START);
      adc_req.cmp_mode <= cmode;
      adc_req.cmp_value <= cmp_reg;
      if (op(`IAMD_OP_WRQ1))
        converter_control_reg <= acc_in;
      if (op(`IAMD_OP_LDCMP) && cmode)
        cmp_reg <= {b_in, acc_in};
    end
  end

  // a completion in the cycle of a clear is kept: set wins
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      conversion_done_flag <= 1'b0;
    else if (conv_done)
      conversion_done_flag <= 1'b1;
    else if (op(`IAMD_OP_START))
      conversion_done_flag <= 1'b0;
    else if (op(`IAMD_OP_TSTAD) && !conv_irq_enable_bit)
      conversion_done_flag <= 1'b0;
  end

  // ----------------------------------------------------------------
  // back-up, watchdog, oscillator
  // ----------------------------------------------------------------
  // arm flags live for exactly one following word
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      backup_armed <= 1'b0;
      wdt_armed    <= 1'b0;
    end
    else if (go)
    begin
      backup_armed <= is_op(instr_word, `IAMD_OP_ARMBK);
      wdt_armed    <= is_op(instr_word, `IAMD_OP_ARMWD);
    end
  end

  // back-up entries are one-cycle requests to the power block
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      backup_keep_detector <= 1'b0;
      backup_full_stop     <= 1'b0;
    end
    else
    begin
      backup_keep_detector <= op(`IAMD_OP_BKEEP) && backup_armed;
      backup_full_stop     <= op(`IAMD_OP_BSTOP) && backup_armed;
    end
  end

  // flag set by the timer wins over the restart clear
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      watchdog_flag_one <= 1'b0;
      watchdog_stopped  <= 1'b0;
    end
    else
    begin
      if (watchdog_flag_set)
        watchdog_flag_one <= 1'b1;
      else if (op(`IAMD_OP_WDRST))
        watchdog_flag_one <= 1'b0;
      if (op(`IAMD_OP_WDRST) && wdt_armed)
        watchdog_stopped <= 1'b1;
    end
  end

  // selection is sticky until the other select; no way back on-chip
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      select_ceramic_clock <= 1'b0;
      select_rc_clock      <= 1'b0;
      onchip_osc_stop      <= 1'b0;
    end
    else if (op(`IAMD_OP_CERAM) || op(`IAMD_OP_RCOSC))
    begin
      select_ceramic_clock <= !instr_word[0];
      select_rc_clock      <= instr_word[0];
      onchip_osc_stop      <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // wishbone slave: ack one cycle after stb, unmapped reads zero
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      wb_ack              <= 1'b0;
      wb_dat_r            <= '0;
      conv_irq_enable_bit <= 1'b0;
    end
    else
    begin
      wb_ack   <= wb_cyc && wb_stb && !wb_ack;
      wb_dat_r <= '0;
      if (wb_cyc && wb_stb && !wb_ack)
      begin
        if (wb_adr == `IAMD_ADR_CFG)
        begin
          wb_dat_r <= {31'h0, conv_irq_enable_bit};
          if (wb_we && wb_sel[0])
            conv_irq_enable_bit <= wb_dat_w[0];
        end
        else if (wb_adr == `IAMD_ADR_STAT)
          wb_dat_r <= {24'h0, clock_control_reg, onchip_osc_stop,
                       watchdog_stopped, watchdog_flag_one,
                       conversion_done_flag};
        else if (wb_adr == `IAMD_ADR_PORT)
          wb_dat_r <= {12'h0, k_latch, c_latch, d_latch, p3_latch,
                       p2_latch, p1_latch, p0_latch};
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  port_write_a: assert property (
    op(`IAMD_OP_WRP0) |=> p0_latch == $past(acc_in))
    else $error("port 0 latch not loaded from accumulator");
  narrow_read_a: assert property (
    op(`IAMD_OP_RDP2) |=> exec.acc_we && exec.acc[3:2] == 2'h0
      && exec.acc[1:0] == $past(p2_pins))
    else $error("narrow port read wrong");
  bitport_skip_a: assert property (
    op(`IAMD_OP_TSTD) && y_in == 4'h2 && !d_pins[2] |=> exec.skip)
    else $error("bitport test did not skip");
  result_hi_a: assert property (
    op(`IAMD_OP_RDHI) && !cmode |=> exec.b == $past(conv_result[9:6])
      && exec.acc == $past(conv_result[5:2]))
    else $error("result high read wrong");
  start_clear_a: assert property (
    op(`IAMD_OP_START) && !conv_done |=> adc_req.start
      && !conversion_done_flag)
    else $error("start did not clear done flag");
  done_nop_a: assert property (
    op(`IAMD_OP_TSTAD) && conv_irq_enable_bit && !conv_done |=> !exec.skip
      && $stable(conversion_done_flag))
    else $error("done test acted with irq enabled");
  backup_arm_a: assert property (
    backup_full_stop |-> $past(op(`IAMD_OP_BSTOP))
      && $past(backup_armed))
    else $error("full stop without arm");
  power_skip_a: assert property (
    op(`IAMD_OP_TSTPW) |=> exec.skip == $past(power_flag))
    else $error("power test skip wrong");
  wdt_stop_a: assert property (
    op(`IAMD_OP_ARMWD) ##1 !instr_valid ##1 op(`IAMD_OP_WDRST) |=>
      watchdog_stopped)
    else $error("watchdog not stopped after arm");
  nop_only_a: assert property (
    op(`IAMD_OP_NOP) |=> exec.pc_inc && !exec.acc_we && !exec.b_we
      && !exec.skip)
    else $error("no-op changed state");

  skip_taken_c:   cover property (exec.skip);
  cmp_load_c:     cover property (op(`IAMD_OP_LDCMP) && cmode);
  backup_keep_c:  cover property (backup_keep_detector);
  wb_read_c:      cover property (wb_ack && !wb_we);

endmodule : iamd_decoder
`default_nettype wire

// *** iamd_fetch_model.sv ***
// fetch-side model: offers one instruction word per call, tracks pc
// assumes: decoder samples the word at the next rising edge
`timescale 1ns/100ps
`default_nettype none
module iamd_fetch_model
(
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  input  wire iamd_pkg::iamd_exec_t exec,
  output logic                      instr_valid,
  output logic [9:0]                instr_word,
  output logic [11:0]               pc
);
  // ----------------------------------------------------------------
  // word issue
  // ----------------------------------------------------------------
  // the word is held to its sampling edge, then the bus shows junk
  // so a decoder that samples late cannot see a stale copy
  task automatic fetch(input logic [9:0] w);
    instr_valid <= 1'b1;
    instr_word  <= w;
    @(posedge clock);
    instr_valid <= 1'b0;
    instr_word  <= ~w;
  endtask : fetch

  // pc follows the advance pulse; a skip jumps one more word
  always_ff @(posedge clock)
    if (!rst_n)
      pc <= 12'h000;
    else if (exec.pc_inc)
      pc <= pc + 12'h001 + {11'h000, exec.skip};

  // idle bus before the first word
  initial
  begin
    instr_valid = 1'b0;
    instr_word  = 10'h000;
  end
endmodule : iamd_fetch_model
`default_nettype wire

// *** tb_top.sv ***
// self-checking bench for the io / converter instruction decoder
// assumes: iamd_pkg and the fetch model compiled before this file
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  typedef struct packed {
    logic [9:0]           w;
    logic [3:0]           a;
    iamd_pkg::iamd_exec_t ex;
    logic [19:0]          pt;
  } iamd_row_t;
  logic        clock, rst_n, instr_valid, k_pin, conv_done, c_latch;
  logic        power_flag, watchdog_flag_set, watchdog_stopped;
  logic        backup_keep_detector, backup_full_stop, k_latch;
  logic        select_ceramic_clock, select_rc_clock, onchip_osc_stop;
  logic        wb_cyc, wb_stb, wb_we, wb_ack;
  logic [1:0]  p2_pins, p3_pins, p2_latch, p3_latch;
  logic [3:0]  acc_in, b_in, y_in, p0_pins, p1_pins, p0_latch;
  logic [3:0]  p1_latch, clock_control_reg, wb_adr, wb_sel;
  logic [5:0]  d_pins, d_latch;
  logic [9:0]  instr_word, conv_result;
  logic [11:0] wake_ctl, pullup_ctl, pc, epc;
  logic [19:0] pv;
  logic [31:0] wb_dat_w, wb_dat_r, q;
  int          fail_count = 0;
  int          n_tests = 0;
  iamd_pkg::iamd_exec_t    exec, ev;
  iamd_pkg::iamd_adc_req_t adc_req;
  iamd_row_t               rq[$];

  // ----------------------------------------------------------------
  // design and fetch model
  // ----------------------------------------------------------------
  iamd_decoder dut_u
  (
    .clock, .rst_n, .instr_valid, .instr_word, .acc_in, .b_in, .y_in,
    .exec, .p0_pins, .p1_pins, .p2_pins, .p3_pins, .d_pins, .k_pin,
    .p0_latch, .p1_latch, .p2_latch, .p3_latch, .d_latch, .c_latch,
    .k_latch, .wake_ctl, .pullup_ctl, .conv_result, .conv_done,
    .adc_req, .power_flag, .watchdog_flag_set, .watchdog_stopped,
    .backup_keep_detector, .backup_full_stop, .select_ceramic_clock,
    .select_rc_clock, .onchip_osc_stop, .clock_control_reg, .wb_cyc,
    .wb_stb, .wb_we, .wb_adr, .wb_sel, .wb_dat_w, .wb_dat_r, .wb_ack
  );
  iamd_fetch_model fm_u
  (
    .clock, .rst_n, .exec, .instr_valid, .instr_word, .pc
  );
  // all output latches seen as one vector
  assign pv = {p0_latch, p1_latch, p2_latch, p3_latch, d_latch,
               c_latch, k_latch};

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_tests++;
    if (g !== x)
    begin
      fail_count++;
      $display("CHECK FAILED %0t got %h want %h", $time, g, x);
    end
  endtask : chk
  function automatic iamd_pkg::iamd_exec_t rd(input logic [3:0] a);
    return '{1'b1, a, 1'b0, 4'h0, 1'b0, 1'b1};
  endfunction : rd
  function automatic iamd_pkg::iamd_exec_t sk(input logic s);
    return '{1'b0, 4'h0, 1'b0, 4'h0, s, 1'b1};
  endfunction : sk
  function automatic iamd_pkg::iamd_exec_t hi(input logic [3:0] b,
                                              input logic [3:0] a);
    return '{1'b1, a, 1'b1, b, 1'b0, 1'b1};
  endfunction : hi
  task automatic row(input logic [9:0] w, input logic [3:0] a,
                     input iamd_pkg::iamd_exec_t x, input logic [19:0] p);
    rq.push_back('{w, a, x, p});
  endtask : row
  // b is the inverse of a and y equals a, so one nibble sets all three
  task automatic run(input logic [9:0] w, input logic [3:0] a);
    @(posedge clock);
    acc_in <= a;
    b_in   <= ~a;
    y_in   <= a;
    fm_u.fetch(w);
    #1 ev = exec;
  endtask : run
  // single wishbone cycle, held until ack is sampled high
  task automatic wb(input logic we, input logic [3:0] ad,
                    input logic [31:0] d);
    @(posedge clock);
    wb_cyc   <= 1'b1;
    wb_stb   <= 1'b1;
    wb_we    <= we;
    wb_adr   <= ad;
    wb_dat_w <= d;
    do
      @(posedge clock);
    while (wb_ack !== 1'b1);
    q = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask : wb
  // one-cycle pulse on the done input or the watchdog flag input
  task automatic pl(input logic wd);
    @(posedge clock);
    conv_done         <= !wd;
    watchdog_flag_set <= wd;
    @(posedge clock);
    conv_done         <= 1'b0;
    watchdog_flag_set <= 1'b0;
  endtask : pl
  task automatic end_sim;
    if (fail_count == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_sim

  // ----------------------------------------------------------------
  // clock and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // the whole run needs under two hundred cycles
  initial
  begin
    repeat (4000) @(posedge clock);
    fail_count++;
    end_sim;
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    rst_n = 1'b0;
    {acc_in, b_in, y_in, epc} = 24'h000000;
    {conv_done, watchdog_flag_set, wb_cyc, wb_stb, wb_we} = 5'h00;
    {wb_adr, wb_dat_w, wb_sel} = 40'h0000000001;
    {p0_pins, p1_pins, p2_pins, p3_pins} = 12'ha59;
    {d_pins, k_pin, power_flag, conv_result} = 18'h2bed6;
    row(10'h000, 4'h0, sk(1'b0), 20'hfffff);
    row(10'h201, 4'h0, sk(1'b0), 20'hfffff);
    row(10'h260, 4'h0, rd(4'ha), 20'hfffff);
    row(10'h262, 4'hf, rd(4'h2), 20'hfffff);
    row(10'h263, 4'hf, rd(4'h1), 20'hfffff);
    row(10'h220, 4'hc, sk(1'b0), 20'hcffff);
    row(10'h222, 4'h5, sk(1'b0), 20'hcf7ff);
    row(10'h014, 4'h2, sk(1'b0), 20'hcf7ef);
    row(10'h014, 4'h6, sk(1'b0), 20'hcf7ef);
    row(10'h015, 4'h2, sk(1'b0), 20'hcf7ff);
    row(10'h014, 4'h5, sk(1'b0), 20'hcf77f);
    row(10'h011, 4'h0, sk(1'b0), 20'hcf7ff);
    row(10'h024, 4'h2, sk(1'b1), 20'hcf7ff);
    row(10'h02b, 4'h0, sk(1'b0), 20'hcf7ff);
    row(10'h024, 4'h1, sk(1'b0), 20'hcf7ff);
    row(10'h02b, 4'h0, sk(1'b0), 20'hcf7ff);
    row(10'h28c, 4'h0, sk(1'b0), 20'hcf7fd);
    row(10'h289, 4'h0, sk(1'b0), 20'hcf7fd);
    row(10'h28d, 4'h0, sk(1'b0), 20'hcf7ff);
    row(10'h289, 4'h0, sk(1'b1), 20'hcf7ff);
    row(10'h21f, 4'he, sk(1'b0), 20'hcf7fe);
    row(10'h26f, 4'hf, rd(4'h1), 20'hcf7fe);
    row(10'h21b, 4'h9, sk(1'b0), 20'hcf7fe);
    row(10'h256, 4'h0, rd(4'h9), 20'hcf7fe);
    row(10'h215, 4'hb, sk(1'b0), 20'hcf7fe);
    row(10'h25a, 4'h0, rd(4'hb), 20'hcf7fe);
    row(10'h214, 4'ha, sk(1'b0), 20'hcf7fe);
    row(10'h22d, 4'h1, sk(1'b0), 20'hcf7fe);
    row(10'h22e, 4'h2, sk(1'b0), 20'hcf7fe);
    row(10'h22f, 4'h3, sk(1'b0), 20'hcf7fe);
    row(10'h216, 4'h6, sk(1'b0), 20'hcf7fe);
    row(10'h252, 4'h0, rd(4'h6), 20'hcf7fe);
    row(10'h249, 4'hf, rd(4'h8), 20'hcf7fe);
    row(10'h279, 4'h0, hi(4'hb, 4'h5), 20'hcf7fe);
    row(10'h204, 4'h8, sk(1'b0), 20'hcf7fe);
    row(10'h244, 4'h0, rd(4'h8), 20'hcf7fe);
    row(10'h239, 4'hc, sk(1'b0), 20'hcf7fe);
    row(10'h279, 4'h0, hi(4'h3, 4'hc), 20'hcf7fe);
    row(10'h204, 4'h0, sk(1'b0), 20'hcf7fe);
    row(10'h239, 4'h7, sk(1'b0), 20'hcf7fe);
    row(10'h204, 4'h8, sk(1'b0), 20'hcf7fe);
    row(10'h279, 4'h0, hi(4'h3, 4'hc), 20'hcf7fe);
    row(10'h003, 4'h0, sk(1'b1), 20'hcf7fe);
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    #1 chk({20'h0, exec}, 32'h0);
    chk({12'h0, pv}, 32'hfffff);
    chk({8'h0, wake_ctl, pullup_ctl}, 32'h0);
    foreach (rq[i])
    begin
      run(rq[i].w, rq[i].a);
      chk({20'h0, ev}, {20'h0, rq[i].ex});
      chk({12'h0, pv}, {12'h0, rq[i].pt});
      epc = epc + 12'h001 + {11'h000, rq[i].ex.skip};
    end
    // done flag: skip-and-clear while the irq enable is off
    pl(1'b0);
    chk({20'h0, pc}, {20'h0, epc});
    run(10'h287, 4'h0);
    chk(32'(ev.skip), 32'h1);
    run(10'h287, 4'h0);
    chk(32'(ev.skip), 32'h0);
    pl(1'b0);
    wb(1'b1, 4'h0, 32'h1);
    run(10'h287, 4'h0);
    chk(32'(ev.skip), 32'h0);
    wb(1'b0, 4'h4, 32'h0);
    chk(32'(q[0]), 32'h1);
    run(10'h29f, 4'h0);
    chk({22'h0, adc_req}, 32'h0000033c);
    run(10'h204, 4'h0);
    run(10'h29f, 4'h0);
    chk({22'h0, adc_req}, 32'h0000023c);
    // watchdog restart, then the stop only right after the arm
    pl(1'b1);
    run(10'h2a0, 4'h0);
    chk(32'(ev.skip), 32'h1);
    run(10'h2a0, 4'h0);
    chk(32'(ev.skip), 32'h0);
    run(10'h29c, 4'h0);
    run(10'h000, 4'h0);
    run(10'h2a0, 4'h0);
    chk(32'(watchdog_stopped), 32'h0);
    run(10'h29c, 4'h0);
    run(10'h2a0, 4'h0);
    chk(32'(watchdog_stopped), 32'h1);
    // back-up entry needs the arm word just before it
    run(10'h002, 4'h0);
    chk(32'(backup_keep_detector), 32'h0);
    run(10'h05b, 4'h0);
    run(10'h002, 4'h0);
    chk(32'(backup_keep_detector), 32'h1);
    run(10'h05b, 4'h0);
    run(10'h008, 4'h0);
    chk(32'(backup_full_stop), 32'h1);
    run(10'h29a, 4'h0);
    chk({30'h0, select_ceramic_clock, onchip_osc_stop}, 32'h3);
    run(10'h29b, 4'h0);
    chk({30'h0, select_rc_clock, onchip_osc_stop}, 32'h3);
    // moved pin levels must show on the next reads
    power_flag  <= 1'b0;
    k_pin       <= 1'b0;
    p0_pins     <= 4'h3;
    conv_result <= 10'h0c1;
    run(10'h003, 4'h0);
    chk(32'(ev.skip), 32'h0);
    run(10'h260, 4'h0);
    chk(32'(ev.acc), 32'h3);
    run(10'h26f, 4'hf);
    chk(32'(ev.acc), 32'h0);
    run(10'h249, 4'hf);
    chk(32'(ev.acc), 32'h4);
    chk({8'h0, wake_ctl, pullup_ctl}, 32'hba9321);
    chk(32'(clock_control_reg), 32'h6);
    wb(1'b0, 4'h8, 32'h0);
    chk(q, 32'h0007fdfc);
    wb(1'b0, 4'h4, 32'h0);
    chk(q, 32'h0000006c);
    wb(1'b1, 4'hc, 32'hffffffff);
    wb(1'b0, 4'hc, 32'h0);
    chk(q, 32'h0);
    end_sim;
  end
endmodule : tb_top
`default_nettype wire
